// File: logic/capture_unit.sv
// Purpose: one position capture unit with pin synchroniser
// Assumes: start_i is already qualified by the owner of the registers
// Notes:   activation wins over a capture that ends a one-shot
`timescale 1ns/100ps
`default_nettype none

module capture_unit #(
  parameter int unsigned POS_W = fpc_pkg::POS_W,
  parameter int unsigned CNT_W = fpc_pkg::CNT_W
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // capture pin and edge choice
  input  wire logic             trig_i,
  input  wire logic             edge_rise_i,
  // activation
  input  wire logic             start_i,
  input  wire logic [1:0]       start_val_i,
  // position source
  input  wire logic [POS_W-1:0] pos_i,
  input  wire logic             redef_i,
  input  wire logic [POS_W-1:0] redef_delta_i,
  // results
  output logic                  level_o,
  output logic                  cap_o,
  output logic [1:0]            mode_o,
  output logic [POS_W-1:0]      pos_o,
  output logic [CNT_W-1:0]      count_o,
  output logic                  done_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ONCE, ST_CONT} run_e;

  run_e state_q;
  run_e state_d;
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic arm;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else if (ce_i) begin
      sync1_q <= trig_i;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign level_o = sync2_q;
  assign arm     = start_i && (start_val_i != fpc_pkg::START_CANCEL);
  assign cap_o   = ce_i && (state_q != ST_IDLE) &&
                   fpc_pkg::edge_seen(prev_q, sync2_q, edge_rise_i);

  always_comb begin
    state_d = state_q;
    if (start_i) begin
      case (start_val_i)
        fpc_pkg::START_ONCE: state_d = ST_ONCE;
        fpc_pkg::START_CONT: state_d = ST_CONT;
        default:             state_d = ST_IDLE;
      endcase
    end else if (cap_o && state_q == ST_ONCE) begin
      state_d = ST_IDLE;
    end
  end

  always_comb begin
    case (state_q)
      ST_ONCE: mode_o = fpc_pkg::START_ONCE;
      ST_CONT: mode_o = fpc_pkg::START_CONT;
      default: mode_o = fpc_pkg::START_CANCEL;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // tally, completion and latched position
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= '0;
    end else if (ce_i) begin
      if (arm) begin
        count_o <= cap_o ? CNT_W'(1) : '0;
      end else if (cap_o) begin
        count_o <= count_o + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
    end else if (ce_i) begin
      if (cap_o) begin
        done_o <= 1'b1;
      end else if (arm) begin
        done_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_o <= '0;
    end else if (ce_i) begin
      if (cap_o) begin
        pos_o <= pos_i;
      end else if (redef_i) begin
        pos_o <= pos_o + redef_delta_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_first_edge;
    cap_o && !start_i && state_q == ST_ONCE;
  endsequence

  sequence s_stopped;
    (mode_o == fpc_pkg::START_CANCEL) && !cap_o;
  endsequence

  AST_ONCE_STOPS: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_first_edge |=> s_stopped)
    else $error("one-shot unit kept running after its capture");

  AST_CONT_HOLDS: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && state_q == ST_CONT && !start_i |=> state_q == ST_CONT)
    else $error("continuous unit stopped without cancel");

  AST_RISE_COUNTS: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && state_q != ST_IDLE && !start_i && edge_rise_i &&
    !prev_q && sync2_q |=> count_o == CNT_W'($past(count_o) + 1'b1))
    else $error("rising edge not counted in rising mode");

  AST_WRONG_EDGE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    edge_rise_i && prev_q && !sync2_q |-> !cap_o)
    else $error("falling edge captured in rising mode");

  AST_TALLY_STEP: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cap_o && !arm |=> count_o == CNT_W'($past(count_o) + 1'b1))
    else $error("tally did not step on capture");

  AST_TALLY_CLEAR: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && arm && !cap_o |=> count_o == '0)
    else $error("tally not cleared on activation");

  AST_POS_LATCH: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cap_o |=> pos_o == $past(pos_i))
    else $error("position not latched on capture");

  AST_POS_REBASE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && redef_i && !cap_o |=>
    pos_o == POS_W'($past(pos_o) + $past(redef_delta_i)))
    else $error("latched position not rebased");

  AST_DONE_CLEAR: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && arm && !cap_o |=> !done_o ##1 (done_o || !$past(cap_o)))
    else $error("completion bit not cleared on activation");

endmodule  // capture_unit

`default_nettype wire

// File: logic/fast_position_capture.sv
// Purpose: two fast position capture units behind parameter addresses
// Assumes: motor position, control mode and rebase come from the core clock
// Notes:   answers come one cycle after a request; CE_I low freezes all
`timescale 1ns/100ps
`default_nettype none

module fast_position_capture #(
  parameter int unsigned POS_W = fpc_pkg::POS_W,
  parameter int unsigned CNT_W = fpc_pkg::CNT_W
) (
  // clock and reset
  input  wire logic                       CORE_CLK_I,
  input  wire logic                       RST_I,
  input  wire logic                       CE_I,
  // capture pins
  input  wire logic                       POSITIVE_LIMIT_SHARED_I,
  input  wire logic                       NEGATIVE_LIMIT_SHARED_I,
  input  wire logic                       INDEX_PULSE_I,
  // drive context
  input  wire logic                       FIELDBUS_MODE_I,
  input  wire logic [POS_W-1:0]           MOTOR_POS_I,
  input  wire logic                       POS_REDEF_I,
  input  wire logic [POS_W-1:0]           POS_REDEF_DELTA_I,
  input  wire logic                       INDEX_ARM_I,
  // parameter access
  input  wire logic [fpc_pkg::ADDR_W-1:0] PAR_ADDR_I,
  input  wire logic                       PAR_WR_I,
  input  wire logic                       PAR_RD_I,
  input  wire logic [fpc_pkg::DATA_W-1:0] PAR_WDATA_I,
  output logic      [fpc_pkg::DATA_W-1:0] PAR_RDATA_O,
  output logic                            PAR_ACK_O,
  output logic                            PAR_ERR_O,
  // status
  output logic                            POSITIVE_LIMIT_LEVEL_O,
  output logic                            NEGATIVE_LIMIT_LEVEL_O,
  output logic      [2:0]                 CAPTURE_DONE_O
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (POS_W < 2 || POS_W > fpc_pkg::DATA_W || CNT_W < 1 ||
      CNT_W > 16) begin : g_bad_width
    $error("unsupported width parameter");
  end

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  logic                       wr_take;
  logic                       rd_take;
  logic                       mapped;
  logic                       val_hi_zero;
  logic [1:0]                 val_lo;
  logic                       start_ok;
  logic                       edge_ok;
  logic                       wr_start1;
  logic                       wr_start2;
  logic                       u1_start;
  logic                       u2_start;
  logic                       wr_bad;
  logic [1:0]                 edge_q;
  logic                       idx_sync1_q;
  logic                       idx_sync2_q;
  logic                       idx_prev_q;
  logic                       idx_edge;
  logic                       idx_done_q;
  logic                       u1_cap;
  logic                       u2_cap;
  logic [1:0]                 u1_mode;
  logic [1:0]                 u2_mode;
  logic [POS_W-1:0]           u1_pos;
  logic [POS_W-1:0]           u2_pos;
  logic [CNT_W-1:0]           u1_tally;
  logic [CNT_W-1:0]           u2_tally;
  logic                       u1_done;
  logic                       u2_done;
  logic [fpc_pkg::DATA_W-1:0] rd_mux;

  assign wr_take     = CE_I && PAR_WR_I;
  assign rd_take     = CE_I && PAR_RD_I && !PAR_WR_I;
  assign mapped      = fpc_pkg::addr_mapped(PAR_ADDR_I);
  assign val_hi_zero = (PAR_WDATA_I[fpc_pkg::DATA_W-1:2] == 30'h00000000);
  assign val_lo      = PAR_WDATA_I[1:0];
  assign start_ok    = val_hi_zero && (val_lo != fpc_pkg::START_RSVD) &&
                       (FIELDBUS_MODE_I ||
                        val_lo == fpc_pkg::START_CANCEL);
  assign edge_ok     = val_hi_zero && !val_lo[1];
  assign wr_start1   = wr_take && PAR_ADDR_I == fpc_pkg::ADDR_U1_START;
  assign wr_start2   = wr_take && PAR_ADDR_I == fpc_pkg::ADDR_U2_START;
  assign u1_start    = wr_start1 && start_ok;
  assign u2_start    = wr_start2 && start_ok;

  always_comb begin
    case (PAR_ADDR_I)
      fpc_pkg::ADDR_U1_START,
      fpc_pkg::ADDR_U2_START: wr_bad = !start_ok;
      fpc_pkg::ADDR_U1_EDGE,
      fpc_pkg::ADDR_U2_EDGE:  wr_bad = !edge_ok;
      default:                wr_bad = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------
  // edge select registers
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      edge_q <= {2{fpc_pkg::EDGE_RESET}};
    end else if (wr_take && edge_ok) begin
      if (PAR_ADDR_I == fpc_pkg::ADDR_U1_EDGE) begin
        edge_q[0] <= val_lo[0];
      end
      if (PAR_ADDR_I == fpc_pkg::ADDR_U2_EDGE) begin
        edge_q[1] <= val_lo[0];
      end
    end
  end

  // ---------------------------------------------------------------
  // capture units, one per shared limit input
  // ---------------------------------------------------------------
  capture_unit #(
    .POS_W (POS_W),
    .CNT_W (CNT_W)
  ) u_first_trigger_input (
    .clk_i         (CORE_CLK_I),
    .rst_i         (RST_I),
    .ce_i          (CE_I),
    .trig_i        (POSITIVE_LIMIT_SHARED_I),
    .edge_rise_i   (edge_q[0]),
    .start_i       (u1_start),
    .start_val_i   (val_lo),
    .pos_i         (MOTOR_POS_I),
    .redef_i       (POS_REDEF_I),
    .redef_delta_i (POS_REDEF_DELTA_I),
    .level_o       (POSITIVE_LIMIT_LEVEL_O),
    .cap_o         (u1_cap),
    .mode_o        (u1_mode),
    .pos_o         (u1_pos),
    .count_o       (u1_tally),
    .done_o        (u1_done)
  );

  capture_unit #(
    .POS_W (POS_W),
    .CNT_W (CNT_W)
  ) u_second_trigger_input (
    .clk_i         (CORE_CLK_I),
    .rst_i         (RST_I),
    .ce_i          (CE_I),
    .trig_i        (NEGATIVE_LIMIT_SHARED_I),
    .edge_rise_i   (edge_q[1]),
    .start_i       (u2_start),
    .start_val_i   (val_lo),
    .pos_i         (MOTOR_POS_I),
    .redef_i       (POS_REDEF_I),
    .redef_delta_i (POS_REDEF_DELTA_I),
    .level_o       (NEGATIVE_LIMIT_LEVEL_O),
    .cap_o         (u2_cap),
    .mode_o        (u2_mode),
    .pos_o         (u2_pos),
    .count_o       (u2_tally),
    .done_o        (u2_done)
  );

  // ---------------------------------------------------------------
  // index pulse capture
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      idx_sync1_q <= 1'b0;
      idx_sync2_q <= 1'b0;
      idx_prev_q  <= 1'b0;
    end else if (CE_I) begin
      idx_sync1_q <= INDEX_PULSE_I;
      idx_sync2_q <= idx_sync1_q;
      idx_prev_q  <= idx_sync2_q;
    end
  end

  assign idx_edge = CE_I && fpc_pkg::edge_seen(idx_prev_q, idx_sync2_q,
                                               fpc_pkg::EDGE_RISE);

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      idx_done_q <= 1'b0;
    end else if (CE_I) begin
      if (idx_edge) begin
        idx_done_q <= 1'b1;
      end else if (INDEX_ARM_I) begin
        idx_done_q <= 1'b0;
      end
    end
  end

  assign CAPTURE_DONE_O = {idx_done_q, u2_done, u1_done};

  // ---------------------------------------------------------------
  // read mux and answer
  // ---------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    case (PAR_ADDR_I)
      fpc_pkg::ADDR_STATUS: begin
        rd_mux[fpc_pkg::ST_BIT_U1]  = u1_done;
        rd_mux[fpc_pkg::ST_BIT_U2]  = u2_done;
        rd_mux[fpc_pkg::ST_BIT_IDX] = idx_done_q;
      end
      fpc_pkg::ADDR_U1_EDGE:  rd_mux[0]         = edge_q[0];
      fpc_pkg::ADDR_U2_EDGE:  rd_mux[0]         = edge_q[1];
      fpc_pkg::ADDR_U1_START: rd_mux[1:0]       = u1_mode;
      fpc_pkg::ADDR_U2_START: rd_mux[1:0]       = u2_mode;
      fpc_pkg::ADDR_U1_POS:   rd_mux[POS_W-1:0] = u1_pos;
      fpc_pkg::ADDR_U2_POS:   rd_mux[POS_W-1:0] = u2_pos;
      fpc_pkg::ADDR_U1_TALLY: rd_mux[CNT_W-1:0] = u1_tally;
      fpc_pkg::ADDR_U2_TALLY: rd_mux[CNT_W-1:0] = u2_tally;
      default:                rd_mux            = '0;
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      PAR_ACK_O <= 1'b0;
      PAR_ERR_O <= 1'b0;
    end else if (CE_I) begin
      PAR_ACK_O <= wr_take || rd_take;
      PAR_ERR_O <= (wr_take && wr_bad) || (rd_take && !mapped);
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      PAR_RDATA_O <= '0;
    end else if (rd_take) begin
      PAR_RDATA_O <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_status_write;
    wr_take && PAR_ADDR_I == fpc_pkg::ADDR_STATUS;
  endsequence

  AST_DECODE_CONT: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    wr_start1 && FIELDBUS_MODE_I && val_hi_zero &&
    val_lo == fpc_pkg::START_CONT |=> u1_mode == fpc_pkg::START_CONT)
    else $error("continuous start not decoded");

  AST_NO_ACT_OUTSIDE_FB: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    wr_start2 && !FIELDBUS_MODE_I &&
    u2_mode == fpc_pkg::START_CANCEL |=>
    u2_mode == fpc_pkg::START_CANCEL &&
    PAR_ERR_O == $past(!val_hi_zero || val_lo != fpc_pkg::START_CANCEL))
    else $error("activation accepted outside fieldbus mode");

  AST_STATUS_RO: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    s_status_write ##1 PAR_ACK_O |-> PAR_ERR_O)
    else $error("status write was not refused");

  AST_STATUS_SET: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    u1_cap |=> CAPTURE_DONE_O[fpc_pkg::ST_BIT_U1])
    else $error("status bit 0 not set by capture");

  AST_INDEX_SET: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    idx_edge |=> CAPTURE_DONE_O[fpc_pkg::ST_BIT_IDX] [*1])
    else $error("status bit 2 not set by index pulse");

  AST_READ_ANSWER: assert property (
    @(posedge CORE_CLK_I) disable iff (RST_I)
    rd_take && PAR_ADDR_I == fpc_pkg::ADDR_U2_TALLY |=>
    PAR_ACK_O && !PAR_ERR_O && PAR_RDATA_O[CNT_W-1:0] == $past(u2_tally))
    else $error("tally read answer wrong");

endmodule  // fast_position_capture

`default_nettype wire

// File: shared/fpc_pkg.sv
// Purpose: constants and helpers shared by the fast position capture block
// Assumes: parameter addresses are 16-bit, data path is 32-bit
// Notes:   positions are two's complement, tallies are unsigned
`default_nettype none

package fpc_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned POS_W  = 32;
  localparam int unsigned CNT_W  = 16;

  // ---------------------------------------------------------------
  // parameter addresses
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 16'h0A02;
  localparam logic [ADDR_W-1:0] ADDR_U1_EDGE  = 16'h0A04;
  localparam logic [ADDR_W-1:0] ADDR_U2_EDGE  = 16'h0A06;
  localparam logic [ADDR_W-1:0] ADDR_U1_START = 16'h0A08;
  localparam logic [ADDR_W-1:0] ADDR_U2_START = 16'h0A0A;
  localparam logic [ADDR_W-1:0] ADDR_U1_POS   = 16'h0A0C;
  localparam logic [ADDR_W-1:0] ADDR_U2_POS   = 16'h0A0E;
  localparam logic [ADDR_W-1:0] ADDR_U1_TALLY = 16'h0A10;
  localparam logic [ADDR_W-1:0] ADDR_U2_TALLY = 16'h0A12;

  // ---------------------------------------------------------------
  // start/stop codes, edge codes, status bits, reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] START_CANCEL = 2'h0;
  localparam logic [1:0] START_ONCE   = 2'h1;
  localparam logic [1:0] START_CONT   = 2'h2;
  localparam logic [1:0] START_RSVD   = 2'h3;
  localparam logic       EDGE_FALL    = 1'h0;
  localparam logic       EDGE_RISE    = 1'h1;
  localparam logic       EDGE_RESET   = 1'h0;
  localparam int unsigned ST_BIT_U1   = 0;
  localparam int unsigned ST_BIT_U2   = 1;
  localparam int unsigned ST_BIT_IDX  = 2;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic edge_seen(input logic prev, input logic cur,
                                     input logic rise);
    edge_seen = rise ? (!prev && cur) : (prev && !cur);
  endfunction

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_STATUS, ADDR_U1_EDGE, ADDR_U2_EDGE, ADDR_U1_START,
      ADDR_U2_START, ADDR_U1_POS, ADDR_U2_POS, ADDR_U1_TALLY,
      ADDR_U2_TALLY: addr_mapped = 1'b1;
      default:       addr_mapped = 1'b0;
    endcase
  endfunction

endpackage

`default_nettype wire

// File: tb/cap_pins.sv
// Purpose: model of the external capture and index signals
// Assumes: levels are held for several core cycles between edges
// Notes:   pins are pushed-pull sources, always driven
`timescale 1ns/100ps
`default_nettype none

module cap_pins (
  // clock
  input  wire logic clk_i,
  // pins
  output logic      pin1_o,
  output logic      pin2_o,
  output logic      idx_o
);
  initial begin
    pin1_o = 1'b0;
    pin2_o = 1'b1;
    idx_o  = 1'b0;
  end

  // set one pin after a falling edge, then hold it six cycles
  task automatic drive(input int n, input logic v);
    @(negedge clk_i);
    if (n == 1) pin1_o = v;
    else if (n == 2) pin2_o = v;
    else idx_o = v;
    repeat (6) @(negedge clk_i);
  endtask
endmodule // cap_pins

`default_nettype wire

// File: tb/tb_fast_position_capture.sv
// Purpose: self-checking bench for the fast position capture block
// Assumes: answers one cycle after a request
// Notes:   reads note expected data, a monitor compares on ack
`timescale 1ns/100ps
`default_nettype none

module tb_fast_position_capture;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        fb, redef, arm, wr, rd, ack, err, l1, l2, p1, p2, ix;
  logic [15:0] addr;
  logic [31:0] mpos, delta, wdata, rdata, v1, v2;
  logic [2:0]  done;
  logic [33:0] notes[$];
  logic [33:0] nt;
  int          failures = 0;
  int          n_tests = 0;
  int          cyc = 0;

  always #4 clk = ~clk;

  cap_pins u_pins (.clk_i(clk), .pin1_o(p1), .pin2_o(p2), .idx_o(ix));

  fast_position_capture u_dut (
    .CORE_CLK_I(clk), .RST_I(rst), .CE_I(ce),
    .POSITIVE_LIMIT_SHARED_I(p1), .NEGATIVE_LIMIT_SHARED_I(p2),
    .INDEX_PULSE_I(ix), .FIELDBUS_MODE_I(fb), .MOTOR_POS_I(mpos),
    .POS_REDEF_I(redef), .POS_REDEF_DELTA_I(delta), .INDEX_ARM_I(arm),
    .PAR_ADDR_I(addr), .PAR_WR_I(wr), .PAR_RD_I(rd), .PAR_WDATA_I(wdata),
    .PAR_RDATA_O(rdata), .PAR_ACK_O(ack), .PAR_ERR_O(err),
    .POSITIVE_LIMIT_LEVEL_O(l1), .NEGATIVE_LIMIT_LEVEL_O(l2),
    .CAPTURE_DONE_O(done)
  );

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // one access; expected answer noted, data checked on good reads
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic e);
    @(negedge clk);
    wr = w;
    rd = ~w;
    addr = a;
    wdata = d;
    notes.push_back({~w & ~e, e, d});
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  always @(negedge clk) begin
    if (ack === 1'b1) begin
      nt = notes.pop_front();
      if (nt[33]) chk({err, rdata}, nt[32:0]);
      else chk({err, 32'h0}, {nt[32], 32'h0});
    end
    cyc++;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    {fb, redef, arm, wr, rd} = 5'h00;
    addr = 16'h0000;
    wdata = 32'h0;
    delta = 32'h0;
    void'($urandom(21896));
    mpos = $urandom;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 9; i++) acc(0, 16'h0A02 + 16'(2 * i), 0, 0);
    acc(0, 16'h0A14, 0, 1);
    acc(1, fpc_pkg::ADDR_STATUS, 32'h7, 1);
    acc(1, fpc_pkg::ADDR_U1_TALLY, 32'h5, 1);
    acc(1, fpc_pkg::ADDR_U1_EDGE, 32'h2, 1);
    acc(1, fpc_pkg::ADDR_U1_START, 32'h1, 1);
    acc(1, fpc_pkg::ADDR_U2_START, 32'h2, 1);
    acc(0, fpc_pkg::ADDR_U1_START, 32'h0, 0);
    fb = 1'b1;
    acc(1, fpc_pkg::ADDR_U1_START, 32'h3, 1);
    acc(1, fpc_pkg::ADDR_U1_EDGE, 32'h1, 0);
    acc(1, fpc_pkg::ADDR_U1_START, 32'h1, 0);
    acc(0, fpc_pkg::ADDR_U1_START, 32'h1, 0);
    v1 = mpos;
    u_pins.drive(1, 1'b1);
    chk({32'h0, l1}, 33'h1);
    mpos = $urandom;
    u_pins.drive(1, 1'b0);
    u_pins.drive(1, 1'b1);
    acc(0, fpc_pkg::ADDR_U1_POS, v1, 0);
    acc(0, fpc_pkg::ADDR_U1_TALLY, 32'h1, 0);
    acc(0, fpc_pkg::ADDR_U1_START, 32'h0, 0);
    acc(1, fpc_pkg::ADDR_U2_START, 32'h2, 0);
    for (int k = 0; k < 3; k++) begin
      mpos = $urandom;
      v2 = mpos;
      u_pins.drive(2, 1'b0);
      u_pins.drive(2, 1'b1);
    end
    chk({32'h0, l2}, 33'h1);
    acc(0, fpc_pkg::ADDR_U2_POS, v2, 0);
    acc(0, fpc_pkg::ADDR_U2_TALLY, 32'h3, 0);
    acc(0, fpc_pkg::ADDR_U2_START, 32'h2, 0);
    acc(1, fpc_pkg::ADDR_U2_START, 32'h0, 0);
    u_pins.drive(2, 1'b0);
    acc(0, fpc_pkg::ADDR_U2_TALLY, 32'h3, 0);
    acc(0, fpc_pkg::ADDR_STATUS, 32'h3, 0);
    delta = $urandom;
    pulse(redef);
    acc(0, fpc_pkg::ADDR_U1_POS, v1 + delta, 0);
    acc(0, fpc_pkg::ADDR_U2_POS, v2 + delta, 0);
    u_pins.drive(3, 1'b1);
    u_pins.drive(3, 1'b0);
    acc(0, fpc_pkg::ADDR_STATUS, 32'h7, 0);
    chk({30'h0, done}, 33'h7);
    pulse(arm);
    acc(1, fpc_pkg::ADDR_U2_START, 32'h1, 0);
    acc(0, fpc_pkg::ADDR_U2_TALLY, 32'h0, 0);
    acc(0, fpc_pkg::ADDR_STATUS, 32'h1, 0);
    acc(1, fpc_pkg::ADDR_U1_START, 32'h2, 0);
    acc(0, fpc_pkg::ADDR_U1_TALLY, 32'h0, 0);
    acc(0, fpc_pkg::ADDR_STATUS, 32'h0, 0);
    // clock enable low: the pin pipeline must hold its last level
    ce = 1'b0;
    u_pins.drive(1, 1'b0);
    chk({32'h0, l1}, 33'h1);
    ce = 1'b1;
    u_pins.drive(1, 1'b1);
    acc(0, fpc_pkg::ADDR_U1_TALLY, 32'h1, 0);
    acc(0, fpc_pkg::ADDR_U1_POS, mpos, 0);
    repeat (4) @(negedge clk);
    wrap_up();
  end
endmodule // tb_fast_position_capture

`default_nettype wire
